// ---- include/rpc_pkg.sv ----
// shared constants and types of the receive per-channel controller
package rpc_pkg;
	// host register offsets of the device
	localparam logic [7:0] CFG_OFS  = 8'h50;
	localparam logic [7:0] STAT_OFS = 8'h51;
	localparam logic [7:0] AC_OFS   = 8'h52;
	localparam logic [7:0] DB_OFS   = 8'h53;
	// reset values
	localparam logic [7:0] CFG_RST  = 8'h00;
	localparam logic [7:0] AC_RST   = 8'h00;
	localparam logic [7:0] DB_RST   = 8'h00;
	// field positions
	localparam int CFG_EN_BIT    = 0;
	localparam int CFG_IND_BIT   = 1;
	localparam int STAT_BUSY_BIT = 7;
	localparam int AC_RW_BIT     = 7;
	localparam int CC_INV_BIT    = 7;
	localparam int CC_TRK_BIT    = 6;
	localparam int CC_MW_BIT     = 5;
	localparam int CC_SIGN_BIT   = 4;
	localparam int STRK_BIT      = 7;
	// internal byte space
	localparam int         CHANNELS  = 24;
	localparam int         INT_BYTES = 3 * CHANNELS;
	localparam logic [6:0] CTRL_BASE = 7'h01;
	localparam logic [6:0] TRK_BASE  = 7'h19;
	localparam logic [6:0] SIG_BASE  = 7'h31;
	// timing
	localparam int CLK_NS     = 25;
	localparam int ACCESS_NS  = 640;
	localparam int ACCESS_CYC = ACCESS_NS / CLK_NS;
	// milliwatt bytes, entry 1 sent first after reset
	localparam logic [7:0][7:0] MW_PAT = {8'h9e, 8'h8b, 8'h8b, 8'h9e,
		8'h1e, 8'h0b, 8'h0b, 8'h1e};
	// host apb map
	localparam logic [11:0] H_CMD_OFS  = 12'h000;
	localparam logic [11:0] H_STAT_OFS = 12'h004;
	localparam logic [11:0] H_CAPT_OFS = 12'h008;
	localparam int H_CMD_WR_BIT = 16;
	typedef enum logic [1:0] {HB_IDLE, HB_ISSUE, HB_WAIT} rpc_hbus_t;
endpackage : rpc_pkg

// ---- include/rpc_if.sv ----
// link between the per-channel controller and its host
interface rpc_if;
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       pcm_bit;
	logic       sig_bit;
	logic       bit_stb;
	logic       frame_stb;
	modport dev (
		input  reg_addr, reg_wr, reg_rd, reg_wdata,
		output reg_rdata, pcm_bit, sig_bit, bit_stb, frame_stb
	);
	modport host (
		output reg_addr, reg_wr, reg_rd, reg_wdata,
		input  reg_rdata, pcm_bit, sig_bit, bit_stb, frame_stb
	);
endinterface : rpc_if

// ---- logic/rpc_device.sv ----
// receive per-channel controller: indirect byte store and pcm modifier
// Overview of operation
// [R1] software must set indirect select to one
// [R2] reset clears indirect select, access disabled
// [R3] enable bit gates all per-channel modifications
// [R4] busy high during access, low after
// [R5] software polls busy low before next access
// [R6] access finishes within 640 ns
// [R7] address write starts access; msb one reads
// [R8] write: load data buffer, then address
// [R9] read: buffer holds byte within 640 ns
// [R10] control, trunk, signalling bytes at 01,19,31
// [R11] control bits: invert, trunk, milliwatt, sign
// [R12] invert alone complements whole byte
// [R13] sign alone complements msb only
// [R14] both flip magnitude; none passes through
// [R15] trunk bit substitutes trunk byte
// [R16] milliwatt bit substitutes milliwatt pattern
// [R17] trunk byte sent msb first
// [R18] milliwatt beats trunk beats inversion
// [R19] same treatment for every framing format
// [R20] signalling trunk bit substitutes signalling code
// [R21] signalling code in low nibble
// [R22] milliwatt advances one byte per frame
// [R23] accesses never disturb the data path
//
// Added by the designer: the APB register port.
module rpc_device (
	input  wire logic clock_in,
	input  wire logic rst_b_in,
	rpc_if.dev        link,
	input  wire logic bit_stb_in,
	input  wire logic frame_start_in,
	input  wire logic pcm_in,
	input  wire logic sig_in
);
	typedef struct packed {
		logic [rpc_pkg::INT_BYTES-1:0][7:0] mem;
		logic [7:0] cfg;
		logic [7:0] ac;
		logic [7:0] db;
		logic       busy;
		logic [4:0] cnt;
		logic [4:0] ch;
		logic [2:0] bitn;
		logic [2:0] mw_ph;
		logic       pcm;
		logic       sig;
		logic       bstb;
		logic       fstb;
		logic [7:0] rdata;
	} rpc_dev_st_t;

	localparam logic [4:0] ACC_LAST = 5'(rpc_pkg::ACCESS_CYC - 1);
	localparam logic [4:0] NCH      = 5'(rpc_pkg::CHANNELS);
	localparam logic [6:0] TRK_IDX  = 7'(rpc_pkg::CHANNELS);
	localparam logic [6:0] SIG_IDX  = 7'(2 * rpc_pkg::CHANNELS);
	localparam logic [6:0] LAST_ADR = rpc_pkg::SIG_BASE + 7'(rpc_pkg::CHANNELS - 1);

	rpc_dev_st_t st_ff;
	rpc_dev_st_t nxt_st;

	logic [4:0] pos_ch;
	logic [2:0] pos_bit;
	logic [7:0] ctrl;
	logic [7:0] trk;
	logic [7:0] strk;
	logic       live;
	logic       flip;
	logic       out_bit;
	logic       out_sig;
	logic [6:0] acc_adr;
	logic       acc_ok;
	logic [6:0] acc_idx;
	logic       enable;
	logic [2:0] mw_now;

	always_comb
	begin
		nxt_st  = st_ff;
		enable  = st_ff.cfg[rpc_pkg::CFG_EN_BIT];
		pos_ch  = frame_start_in ? 5'h00 : st_ff.ch;
		pos_bit = frame_start_in ? 3'h0 : st_ff.bitn;
		// the frame start bit already uses the new byte, so channel 1 is not split
		mw_now  = frame_start_in ? st_ff.mw_ph + 3'h1 : st_ff.mw_ph;
		live    = enable && (pos_ch < NCH); // [R3]
		// combinational reads of the store keep the stream running [R23]
		ctrl    = 8'h00;
		trk     = 8'h00;
		strk    = 8'h00;
		if (pos_ch < NCH)
		begin
			ctrl = st_ff.mem[7'(pos_ch)]; // [R10]
			trk  = st_ff.mem[7'(pos_ch) + TRK_IDX];
			strk = st_ff.mem[7'(pos_ch) + SIG_IDX];
		end
		// msb gets invert^sign, others invert [R12] [R13] [R14]
		if (pos_bit == 3'h0)
		begin
			flip = ctrl[rpc_pkg::CC_INV_BIT] ^ ctrl[rpc_pkg::CC_SIGN_BIT];
		end
		else
		begin
			flip = ctrl[rpc_pkg::CC_INV_BIT];
		end
		// no framing input: treatment is format blind [R19]
		out_bit = pcm_in;
		if (live)
		begin
			if (ctrl[rpc_pkg::CC_MW_BIT]) // [R18]
			begin
				out_bit = rpc_pkg::MW_PAT[mw_now][3'h7 - pos_bit]; // [R16]
			end
			else if (ctrl[rpc_pkg::CC_TRK_BIT])
			begin
				out_bit = trk[3'h7 - pos_bit]; // [R15] [R17]
			end
			else
			begin
				out_bit = pcm_in ^ flip; // [R11]
			end
		end
		out_sig = sig_in;
		if (live && strk[rpc_pkg::STRK_BIT] && pos_bit[2]) // [R20]
		begin
			out_sig = strk[3'h7 - pos_bit]; // [R21]
		end

		// bit stream timing
		nxt_st.bstb = bit_stb_in;
		nxt_st.fstb = bit_stb_in && frame_start_in;
		if (bit_stb_in)
		begin
			nxt_st.pcm  = out_bit;
			nxt_st.sig  = out_sig;
			nxt_st.bitn = pos_bit + 3'h1;
			nxt_st.ch   = pos_ch;
			if (pos_bit == 3'h7 && pos_ch < NCH)
			begin
				nxt_st.ch = pos_ch + 5'h01;
			end
			if (frame_start_in)
			begin
				nxt_st.mw_ph = mw_now; // [R22]
			end
		end

		// host register reads, answered one cycle after the strobe
		acc_adr = st_ff.ac[6:0];
		acc_ok  = (acc_adr >= rpc_pkg::CTRL_BASE) && (acc_adr <= LAST_ADR);
		acc_idx = acc_adr - rpc_pkg::CTRL_BASE;
		if (link.reg_rd)
		begin
			unique case (link.reg_addr)
				rpc_pkg::CFG_OFS:  nxt_st.rdata = {6'h00, st_ff.cfg[1:0]};
				rpc_pkg::STAT_OFS: nxt_st.rdata = {st_ff.busy, 7'h00}; // [R4]
				rpc_pkg::AC_OFS:   nxt_st.rdata = st_ff.ac;
				rpc_pkg::DB_OFS:   nxt_st.rdata = st_ff.db;
				default:           nxt_st.rdata = 8'h00;
			endcase
		end

		// host register writes; buffer and address are locked while busy
		if (link.reg_wr)
		begin
			if (link.reg_addr == rpc_pkg::CFG_OFS)
			begin
				nxt_st.cfg = {6'h00, link.reg_wdata[1:0]};
			end
			if (link.reg_addr == rpc_pkg::DB_OFS && !st_ff.busy)
			begin
				nxt_st.db = link.reg_wdata; // [R8]
			end
			if (link.reg_addr == rpc_pkg::AC_OFS && !st_ff.busy)
			begin
				nxt_st.ac = link.reg_wdata;
				// without indirect select the store cannot be reached [R2]
				if (st_ff.cfg[rpc_pkg::CFG_IND_BIT])
				begin
					nxt_st.busy = 1'b1; // [R7] [R4]
					nxt_st.cnt  = ACC_LAST;
				end
			end
		end

		// access completes when the count runs out [R6]
		if (st_ff.busy)
		begin
			nxt_st.cnt = st_ff.cnt - 5'h01;
			if (st_ff.cnt == 5'h00)
			begin
				nxt_st.busy = 1'b0; // [R4]
				if (st_ff.ac[rpc_pkg::AC_RW_BIT])
				begin
					// unmapped address reads as zero
					nxt_st.db = acc_ok ? st_ff.mem[acc_idx] : 8'h00; // [R9]
				end
				else if (acc_ok)
				begin
					nxt_st.mem[acc_idx] = st_ff.db; // [R7]
				end
			end
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			st_ff      <= '0;
			st_ff.cfg  <= rpc_pkg::CFG_RST; // [R2]
			st_ff.ac   <= rpc_pkg::AC_RST;
			st_ff.db   <= rpc_pkg::DB_RST;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign link.reg_rdata = st_ff.rdata;
	assign link.pcm_bit   = st_ff.pcm;
	assign link.sig_bit   = st_ff.sig;
	assign link.bit_stb   = st_ff.bstb;
	assign link.frame_stb = st_ff.fstb;
endmodule : rpc_device

// ---- logic/rpc_host.sv ----
// host end: apb command port to the controller registers, pcm capture
module rpc_host (
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	rpc_if.host              link,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out
);
	typedef struct packed {
		rpc_pkg::rpc_hbus_t hb;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
		logic       is_wr;
		logic [7:0] rdata;
		logic [4:0] ch;
		logic [2:0] bitn;
		logic [6:0] pcm_sh;
		logic [2:0] sig_sh;
		logic [7:0] capt_pcm;
		logic [3:0] capt_sig;
		logic [4:0] capt_ch;
	} rpc_host_st_t;

	rpc_host_st_t st_ff;
	rpc_host_st_t nxt_st;

	logic       acc;
	logic       busy;
	logic       mapped;
	logic [4:0] pos_ch;
	logic [2:0] pos_bit;

	always_comb
	begin
		nxt_st  = st_ff;
		acc     = psel_in && penable_in;
		busy    = (st_ff.hb != rpc_pkg::HB_IDLE);
		mapped  = (paddr_in == rpc_pkg::H_CMD_OFS) || (paddr_in == rpc_pkg::H_STAT_OFS)
			|| (paddr_in == rpc_pkg::H_CAPT_OFS);
		pos_ch  = link.frame_stb ? 5'h00 : st_ff.ch;
		pos_bit = link.frame_stb ? 3'h0 : st_ff.bitn;
		nxt_st.wr = 1'b0;
		nxt_st.rd = 1'b0;
		unique case (st_ff.hb)
			rpc_pkg::HB_IDLE:
			begin
				// software orders select, buffer, address, busy polls [R1] [R8] [R5]
				if (acc && pwrite_in && paddr_in == rpc_pkg::H_CMD_OFS)
				begin
					nxt_st.addr  = pwdata_in[7:0];
					nxt_st.wdata = pwdata_in[15:8];
					nxt_st.is_wr = pwdata_in[rpc_pkg::H_CMD_WR_BIT];
					nxt_st.wr    = pwdata_in[rpc_pkg::H_CMD_WR_BIT]; // [R7]
					nxt_st.rd    = !pwdata_in[rpc_pkg::H_CMD_WR_BIT];
					nxt_st.hb    = rpc_pkg::HB_ISSUE;
				end
			end
			rpc_pkg::HB_ISSUE:
			begin
				nxt_st.hb = rpc_pkg::HB_WAIT;
			end
			rpc_pkg::HB_WAIT:
			begin
				if (!st_ff.is_wr)
				begin
					nxt_st.rdata = link.reg_rdata;
				end
				nxt_st.hb = rpc_pkg::HB_IDLE;
			end
		endcase
		// capture each finished channel byte of the stream
		if (link.bit_stb)
		begin
			nxt_st.pcm_sh = {st_ff.pcm_sh[5:0], link.pcm_bit};
			nxt_st.sig_sh = {st_ff.sig_sh[1:0], link.sig_bit};
			nxt_st.bitn   = pos_bit + 3'h1;
			nxt_st.ch     = pos_ch;
			if (pos_bit == 3'h7)
			begin
				nxt_st.capt_pcm = {st_ff.pcm_sh, link.pcm_bit};
				nxt_st.capt_sig = {st_ff.sig_sh, link.sig_bit};
				nxt_st.capt_ch  = pos_ch;
				if (pos_ch < 5'(rpc_pkg::CHANNELS))
				begin
					nxt_st.ch = pos_ch + 5'h01;
				end
			end
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			st_ff    <= '0;
			st_ff.hb <= rpc_pkg::HB_IDLE;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	always_comb
	begin
		unique case (paddr_in)
			rpc_pkg::H_STAT_OFS: prdata_out = {16'h0000, st_ff.rdata, 7'h00, busy};
			rpc_pkg::H_CAPT_OFS: prdata_out = {11'h000, st_ff.capt_ch, 4'h0,
				st_ff.capt_sig, st_ff.capt_pcm};
			default:             prdata_out = 32'h0000_0000;
		endcase
	end

	assign pready_out     = 1'b1;
	assign pslverr_out    = psel_in && penable_in && !mapped;
	assign link.reg_addr  = st_ff.addr;
	assign link.reg_wdata = st_ff.wdata;
	assign link.reg_wr    = st_ff.wr;
	assign link.reg_rd    = st_ff.rd;
endmodule : rpc_host

// ---- testbench/rpc_monitor.sv ----
// concurrent checks on the controller link
module rpc_monitor (
	input wire logic       clock_in,
	input wire logic       rst_b_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_in,
	input wire logic       pcm_bit_in,
	input wire logic       sig_bit_in,
	input wire logic       bit_stb_in,
	input wire logic       frame_stb_in
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [4:0] ACC_CNT = 5'(rpc_pkg::ACCESS_CYC);
	logic [1:0] cfg_ff;
	logic [4:0] cnt_ff;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	// shadow of select bits and access timer
	always_ff @(posedge clock_in)
	begin
		if (!rst_b_in)
		begin
			cfg_ff <= 2'h0;
			cnt_ff <= 5'h0;
		end
		else
		begin
			if (reg_wr_in && reg_addr_in == rpc_pkg::CFG_OFS)
				cfg_ff <= reg_wdata_in[1:0];
			if (reg_wr_in && reg_addr_in == rpc_pkg::AC_OFS
				&& cfg_ff[rpc_pkg::CFG_IND_BIT] && cnt_ff == 5'h0)
				cnt_ff <= ACC_CNT;
			else if (cnt_ff != 5'h0)
				cnt_ff <= cnt_ff - 5'h1;
		end
	end
	AST_CFG: assert property (reg_rd_in && reg_addr_in == rpc_pkg::CFG_OFS |=>
		reg_rdata_in == {6'h0, $past(cfg_ff)}) else $error("bad cfg read");
	AST_BUSY: assert property (reg_rd_in && reg_addr_in == rpc_pkg::STAT_OFS |=>
		reg_rdata_in == {($past(cnt_ff) != 5'h0), 7'h0}) else $error("bad busy");
	AST_UNMAP: assert property (reg_rd_in && (reg_addr_in < rpc_pkg::CFG_OFS ||
		reg_addr_in > rpc_pkg::DB_OFS) |=> reg_rdata_in == 8'h0)
		else $error("bad unmapped read");
	AST_HOLDR: assert property ($past(rst_b_in) && !$past(reg_rd_in) |->
		$stable(reg_rdata_in)) else $error("read data moved");
	AST_ONE: assert property (reg_wr_in || reg_rd_in |=> !reg_wr_in && !reg_rd_in)
		else $error("long request");
	AST_EXCL: assert property (!(reg_wr_in && reg_rd_in))
		else $error("read with write");
	AST_FRM: assert property (frame_stb_in |-> bit_stb_in)
		else $error("lone frame mark");
	AST_HOLDS: assert property ($past(rst_b_in) && !bit_stb_in |->
		$stable({pcm_bit_in, sig_bit_in})) else $error("stream moved");
	cover property (reg_wr_in && reg_addr_in == rpc_pkg::AC_OFS);
	cover property (reg_rd_in && reg_addr_in == rpc_pkg::STAT_OFS ##1 reg_rdata_in[7]);
	cover property (frame_stb_in);
endmodule : rpc_monitor

// ---- testbench/test_receive_per_channel_controller.sv ----
// bench: apb host end driving the controller, stream checked on the link
module test_receive_per_channel_controller;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] D = 8'h3c;
	logic        clock_in = 1'h0, rst_b_in = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
	logic        stb = 1'h0, fs = 1'h0, pin = 1'h0, prdy, perr, qerr;
	logic [11:0] pa = 12'h0;
	logic [31:0] pwd = 32'h0, prd, q;
	logic [7:0]  got [24], gsg [24];
	logic [7:0]  ctl [8] = '{8'h20, 8'h80, 8'h10, 8'h90, 8'h40, 8'hf0, 8'hc0, 8'h20};
	int          miscompares = 0, num_checks = 0, cyc = 0, pos = 0, nf = 0;
	rpc_if link ();
	rpc_device i_rpc_device (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link.dev),
		.bit_stb_in(stb), .frame_start_in(fs), .pcm_in(pin), .sig_in(pin));
	rpc_host i_rpc_host (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link.host),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.prdata_out(prd), .pready_out(prdy), .pslverr_out(perr));
	rpc_monitor i_rpc_monitor (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.reg_addr_in(link.reg_addr), .reg_wr_in(link.reg_wr), .reg_rd_in(link.reg_rd),
		.reg_wdata_in(link.reg_wdata), .reg_rdata_in(link.reg_rdata),
		.pcm_bit_in(link.pcm_bit), .sig_bit_in(link.sig_bit), .bit_stb_in(link.bit_stb),
		.frame_stb_in(link.frame_stb));
	always #12.5 clock_in = ~clock_in;
	// timeout and stream collector, msb first
	always @(posedge clock_in)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			miscompares++;
			stop_test();
		end
		if (link.bit_stb === 1'h1)
		begin
			if (link.frame_stb === 1'h1)
				pos = 0;
			if (pos < 192)
			begin
				got[pos / 8] = {got[pos / 8][6:0], link.pcm_bit};
				gsg[pos / 8] = {gsg[pos / 8][6:0], link.sig_bit};
			end
			pos++;
		end
	end
	task cmp(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_in);
		psel <= 1'h1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clock_in);
		pen <= 1'h1;
		// no local limit: only the cycle ceiling ends a hung wait
		do
		begin
			@(posedge clock_in);
		end
		while (prdy !== 1'h1);
		q = prd;
		qerr = perr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask : apb
	// one device register access, waits for the host end to go idle
	task dev(input logic w, input logic [7:0] a, input logic [7:0] d);
		apb(1'h1, rpc_pkg::H_CMD_OFS, {15'h0, w, d, a});
		q = 32'h1;
		while (q[0] !== 1'h0)
			apb(1'h0, rpc_pkg::H_STAT_OFS, 32'h0);
	endtask : dev
	task indirect_access_select(input logic w, input logic [6:0] a, input logic [7:0] d);
		if (w)
			dev(1'h1, rpc_pkg::DB_OFS, d);
		dev(1'h1, rpc_pkg::AC_OFS, {~w, a});
		dev(1'h0, rpc_pkg::STAT_OFS, 8'h0);
		cmp(q[15:8], 8'h80);
		for (int n = 0; n < 5 && q[15] !== 1'h0; n++)
			dev(1'h0, rpc_pkg::STAT_OFS, 8'h0);
		cmp(q[15:8], 8'h00);
		if (!w)
			dev(1'h0, rpc_pkg::DB_OFS, 8'h0);
	endtask : indirect_access_select
	task frame(input logic en);
		logic [7:0] m, k;
		m = rpc_pkg::MW_PAT[(nf + 1) % 8];
		for (int i = 0; i < 192; i++)
		begin
			@(posedge clock_in);
			stb <= 1'h1;
			fs <= (i == 0);
			pin <= D[7 - i % 8];
		end
		@(posedge clock_in);
		stb <= 1'h0;
		fs <= 1'h0;
		repeat (3) @(posedge clock_in);
		nf++;
		for (int c = 0; c < 24; c++)
		begin
			k = (en && c < 8) ? ctl[c] : 8'h0;
			cmp(got[c], k[5] ? m : k[6] ? 8'ha0 | c[7:0] : D ^ {k[7] ^ k[4], {7{k[7]}}});
			cmp(gsg[c], (en && c < 8 && c[0]) ? {D[7:4], 4'h9 ^ c[3:0]} : D);
		end
		// host end capture holds the last channel, never modified here
		apb(1'h0, rpc_pkg::H_CAPT_OFS, 32'h0);
		cmp(q[7:0], D);
		cmp(q[15:8], {4'h0, D[3:0]});
		cmp({3'h0, q[20:16]}, 8'(rpc_pkg::CHANNELS - 1));
	endtask : frame
	task t_regs;
		dev(1'h0, rpc_pkg::CFG_OFS, 8'h0);
		cmp(q[15:8], rpc_pkg::CFG_RST);
		dev(1'h1, rpc_pkg::AC_OFS, 8'h81);
		dev(1'h0, rpc_pkg::STAT_OFS, 8'h0);
		cmp(q[15:8], 8'h00);
		dev(1'h0, 8'h60, 8'h0);
		cmp(q[15:8], 8'h00);
		apb(1'h0, 12'h00c, 32'h0);
		cmp({7'h0, qerr}, 8'h01);
		cmp(q[7:0], 8'h00);
		dev(1'h1, rpc_pkg::CFG_OFS, 8'hff);
		dev(1'h0, rpc_pkg::CFG_OFS, 8'h0);
		cmp(q[15:8], 8'h03);
		cmp({7'h0, qerr}, 8'h00);
		$display("t_regs done");
	endtask : t_regs
	task t_store;
		for (int i = 0; i < 8; i++)
		begin
			indirect_access_select(1'h1, rpc_pkg::CTRL_BASE + i[6:0], ctl[i]);
			indirect_access_select(1'h1, rpc_pkg::TRK_BASE + i[6:0], 8'ha0 | i[7:0]);
			indirect_access_select(1'h1, rpc_pkg::SIG_BASE + i[6:0], {i[0], 3'h0, 4'h9 ^ i[3:0]});
		end
		indirect_access_select(1'h0, rpc_pkg::TRK_BASE + 7'h4, 8'h0);
		cmp(q[15:8], 8'ha4);
		indirect_access_select(1'h0, 7'h50, 8'h0);
		cmp(q[15:8], 8'h00);
		$display("t_store done");
	endtask : t_store
	task t_stream;
		frame(1'h1);
		dev(1'h1, rpc_pkg::CFG_OFS, 8'h02);
		frame(1'h0);
		dev(1'h1, rpc_pkg::CFG_OFS, 8'h03);
		// an indirect read runs while the stream flows
		fork
			frame(1'h1);
			begin
				indirect_access_select(1'h0, rpc_pkg::TRK_BASE + 7'h6, 8'h0);
				cmp(q[15:8], 8'ha6);
			end
		join
		$display("t_stream done");
	endtask : t_stream
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	initial
	begin
		repeat (8) @(posedge clock_in);
		rst_b_in <= 1'h1;
		t_regs();
		t_store();
		t_stream();
		stop_test();
	end
endmodule : test_receive_per_channel_controller
